// ---- src/fsoc_pkg.sv ----
// constants, field layouts and carrier types of the fail-safe output control
// assumes a single 100 MHz clock shared by all fail-safe logic
package fsoc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_FREQ_KHZ = 100_000;
  localparam int MS_TICK_MS = 1;
  localparam int MS_TICK_CYC = CLK_FREQ_KHZ * MS_TICK_MS;
  localparam int RST_HOLD_US = 10;
  localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_FREQ_KHZ / 1000;
  localparam logic [11:0] STEP_SHORT_MS = 12'h00A;
  localparam logic [11:0] STEP_LONG_MS = 12'h0D2;

  // ****************************************
  // fault counter levels
  // ****************************************
  localparam logic [2:0] FLT_START = 3'h1;
  localparam logic [2:0] FLT_MAX = 3'h7;
  localparam logic [2:0] FLT_INTER_LO = 3'h3;
  localparam logic [2:0] FLT_FINAL_LO = 3'h6;
  localparam logic [2:0] FLT_INTER_HI = 3'h1;
  localparam logic [2:0] FLT_FINAL_HI = 3'h2;
  localparam logic [3:0] WDOG_ERR_STEP = 4'h2;

  // ****************************************
  // effect selector encodings (bit 0 reset, bit 1 primary)
  // ****************************************
  localparam int EFF_RST_BIT = 0;
  localparam int EFF_SAFE_BIT = 1;
  // the fault level selector orders its bits the other way round
  localparam int FLT_EFF_SAFE_BIT = 0;
  localparam int FLT_EFF_RST_BIT = 1;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic wdogMax;
    logic underVolt;
    logic overVolt;
    logic feedback;
    logic extIc;
    logic faultLevel;
  } fsoc_src_en_t;

  typedef struct packed {
    logic [1:0] wdogEffectSel;
    logic [1:0] faultCountEffectSel;
    logic faultThresholdSel;
    logic [2:0] wdogErrLimit;
    logic [2:0] wdogGoodLimit;
    fsoc_src_en_t rstSrcEn;
    fsoc_src_en_t safeSrcEn;
  } fsoc_cfg_t;

  localparam fsoc_cfg_t CFG_RESET = '{
    wdogEffectSel: 2'h3, faultCountEffectSel: 2'h3,
    faultThresholdSel: 1'b0, wdogErrLimit: 3'h6, wdogGoodLimit: 3'h6,
    rstSrcEn: 6'h3F, safeSrcEn: 6'h3F};

  typedef struct packed {
    logic coreUv;
    logic analogUv;
    logic auxUv;
    logic coreOv;
    logic analogOv;
    logic auxOv;
    logic feedbackFault;
    logic extIcErr;
    logic preregOv;
    logic selftestFail;
    logic primaryShortHigh;
    logic resetShortHigh;
    logic secondaryShortHigh;
  } fsoc_faults_t;

  typedef struct packed {
    logic durationMode;
    logic [3:0] timeCode;
    logic timeScale;
  } fsoc_sec_cfg_t;

  typedef enum logic [1:0] {
    SEC_IDLE = 2'b00,
    SEC_DELAY = 2'b01,
    SEC_HOLD = 2'b10,
    SEC_DURATION = 2'b11
  } fsoc_sec_state_t;

endpackage

// ---- src/fsoc_ms_tick.sv ----
// millisecond tick divider for the secondary output timer
// assumes clear is a one-cycle pulse from the same clock domain
`timescale 1ns/10ps
module fsoc_ms_tick
  import fsoc_pkg::*;
#(
  parameter int TICK_CYC = MS_TICK_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic clear,
  // tick
  output logic tick
);

  logic [19:0] count_q;
  logic [19:0] count_d;
  wire atEnd = (count_q == 20'(TICK_CYC - 1));

  assign count_d = (clear || atEnd) ? 20'h0_0000 : count_q + 20'h0_0001;

  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= 20'h0_0000;
      tick <= 1'b0;
    end else begin
      count_q <= count_d;
      tick <= atEnd && !clear;
    end
  end

endmodule

// ---- src/fsoc_sec_timer.sv ----
// secondary safe output sequencer: delay mode and duration mode
// assumes start is the cycle in which the primary output goes low
`timescale 1ns/10ps
module fsoc_sec_timer
  import fsoc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // timing
  input wire logic msTick,
  input wire logic start,
  input wire fsoc_sec_cfg_t secCfg,
  // release
  input wire logic release_req,
  input wire logic switchClosed,
  // output
  output logic secondaryN_q
);

  fsoc_sec_state_t state_q;
  fsoc_sec_state_t state_d;
  logic [11:0] msCount_q;
  logic [11:0] msCount_d;

  wire [11:0] stepMs = secCfg.timeScale ? STEP_LONG_MS : STEP_SHORT_MS;
  wire [11:0] targetMs = 12'({8'h00, secCfg.timeCode} * stepMs);
  wire zeroTime = (targetMs == 12'h000);
  wire expired = msTick && (msCount_q + 12'h001 >= targetMs);
  wire releaseOk = release_req && switchClosed;

  always_comb begin
    state_d = state_q;
    msCount_d = msTick ? msCount_q + 12'h001 : msCount_q;
    if (start) begin
      msCount_d = 12'h000;
      if (secCfg.durationMode) begin
        state_d = zeroTime ? SEC_IDLE : SEC_DURATION;
      end else begin
        state_d = zeroTime ? SEC_HOLD : SEC_DELAY;
      end
    end else begin
      case (state_q)
        SEC_DELAY: if (expired) begin
          state_d = SEC_HOLD;
        end
        SEC_HOLD: if (releaseOk) begin
          state_d = SEC_IDLE;
        end
        SEC_DURATION: if (expired) begin
          state_d = SEC_IDLE;
        end
        SEC_IDLE: state_d = SEC_IDLE;
        default: state_d = SEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= SEC_IDLE;
      msCount_q <= 12'h000;
      secondaryN_q <= 1'b1;
    end else begin
      state_q <= state_d;
      msCount_q <= msCount_d;
      secondaryN_q <= !(state_d == SEC_HOLD || state_d == SEC_DURATION);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_SEC_ZERO_DELAY: assert property (
    start && zeroTime && !secCfg.durationMode |=> !secondaryN_q)
    else $error("secondary not low with zero delay");
  AST_SEC_HOLD_SWITCH: assert property (
    !secondaryN_q && state_q == SEC_HOLD && !switchClosed && !start
    |=> !secondaryN_q)
    else $error("secondary released with switch open");
  AST_SEC_DUR_START: assert property (
    start && !zeroTime && secCfg.durationMode |=> !secondaryN_q)
    else $error("secondary not low at duration start");

endmodule

// ---- src/fsoc_core.sv ----
// fail-safe output control: fault counter, reset and safe output decisions
// assumes watchdog, spi and unlock checks are done by neighbouring logic on
// the same clock; analog fault flags arrive asynchronously
//
// Functional notes
// - watchdog error maximum adds one fault
// - mode 01: wdog resets, level drives primary
// - mode 10: wdog primary, level+max drives reset
// - start and low power exit: count one, primary low
// - primary release needs zero count, unlock word
// - default limit six: seven goods lower count
// - reset sources maskable during init phase
// - fixed reset sources, no override
// - primary sources maskable during init phase
// - fixed primary sources, no override
// - secondary follows primary, delay or duration
// - delay mode: low after delay, software release
// - time from four-bit code and scale
// - zero delay asserts with primary
// - pull-up switch opens first, closed by request
// - duration mode: low then self release
// - same time code for duration, digital timing
// - threshold select picks intermediate, final levels
// - any reset or primary assertion adds one, once per cycle
// - failure adds two, good refresh subtracts one
// - good counter at limit plus good decrements
`timescale 1ns/10ps
module fsoc_core
  import fsoc_pkg::*;
#(
  parameter int TICK_CYC = MS_TICK_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // state events from neighbouring logic
  input wire logic lowPowerOffExit,
  input wire logic safetyInitPhase,
  input wire logic wdogGood,
  input wire logic wdogBad,
  input wire logic initRefreshBad,
  // spi requests and configuration
  input wire fsoc_cfg_t cfgIn,
  input wire fsoc_sec_cfg_t secCfg,
  input wire logic spiResetReq,
  input wire logic spiSafeReq,
  input wire logic doubleErrorDetect,
  input wire logic pullupSwitchCloseReq,
  input wire logic primaryUnlockOk,
  input wire logic secondaryUnlockOk,
  // asynchronous fault flags
  input wire fsoc_faults_t faultsAsync,
  // outputs
  output logic resetOutN_q,
  output logic primarySafeOutN_q,
  output logic secondarySafeOutN_q,
  output logic pullupSwitchClosed_q,
  output logic [2:0] faultCount_q,
  output logic faultFinal_q,
  output logic [3:0] wdogErrCount_q
);

  // ****************************************
  // synchronisers and latched configuration
  // ****************************************
  fsoc_faults_t faultsMeta_q;
  fsoc_faults_t faults_q;
  fsoc_faults_t faultsPrev_q;
  fsoc_cfg_t cfg_q;
  logic [2:0] goodCount_q;
  logic [2:0] goodCount_d;
  logic [3:0] wdogErrCount_d;
  logic [2:0] faultCount_d;
  logic primaryN_d;
  logic [15:0] rstCnt_q;
  logic [15:0] rstCnt_d;
  logic msTick;

  always_ff @(posedge clock) begin
    if (rst) begin
      faultsMeta_q <= '0;
      faults_q <= '0;
      faultsPrev_q <= '0;
    end else begin
      faultsMeta_q <= faultsAsync;
      faults_q <= faultsMeta_q;
      faultsPrev_q <= faults_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else if (safetyInitPhase) begin
      cfg_q <= cfgIn;
    end
  end

  // ****************************************
  // watchdog counters
  // ****************************************
  wire [3:0] wdogErrSum = wdogErrCount_q + WDOG_ERR_STEP;
  wire wdogMax = wdogBad && (wdogErrSum >= {1'b0, cfg_q.wdogErrLimit});
  wire goodAtLimit = (goodCount_q == cfg_q.wdogGoodLimit);
  wire faultDec = wdogGood && goodAtLimit;

  assign wdogErrCount_d = wdogMax ? 4'h0 :
                          wdogBad ? wdogErrSum :
                          (wdogGood && wdogErrCount_q != 4'h0) ?
                          wdogErrCount_q - 4'h1 : wdogErrCount_q;
  assign goodCount_d = wdogBad ? 3'h0 :
                       faultDec ? 3'h0 :
                       wdogGood ? goodCount_q + 3'h1 : goodCount_q;

  // ****************************************
  // fault levels
  // ****************************************
  // threshold select
  wire [2:0] interLevel = cfg_q.faultThresholdSel ? FLT_INTER_HI :
                          FLT_INTER_LO;
  wire [2:0] finalLevel = cfg_q.faultThresholdSel ? FLT_FINAL_HI :
                          FLT_FINAL_LO;
  wire atInter = (faultCount_q >= interLevel);

  wire uvLevel = faults_q.coreUv || faults_q.analogUv || faults_q.auxUv;
  wire ovLevel = faults_q.coreOv || faults_q.analogOv || faults_q.auxOv;
  fsoc_faults_t faultRise;
  assign faultRise = faults_q & ~faultsPrev_q;
  wire uvRise = faultRise.coreUv || faultRise.analogUv || faultRise.auxUv;
  wire ovRise = faultRise.coreOv || faultRise.analogOv || faultRise.auxOv;
  wire anyFaultLevel = uvLevel || ovLevel || faults_q.feedbackFault ||
                       faults_q.extIcErr || faults_q.preregOv ||
                       faults_q.selftestFail || faults_q.primaryShortHigh ||
                       faults_q.resetShortHigh || faults_q.secondaryShortHigh;

  // ****************************************
  // reset output causes
  // ****************************************
  // fixed reset causes
  wire rstFixed = faultRise.preregOv || initRefreshBad ||
                  faultRise.primaryShortHigh || spiResetReq;
  // maskable reset causes; wdog effect on reset
  wire rstWdog = cfg_q.rstSrcEn.wdogMax && wdogMax &&
                 cfg_q.wdogEffectSel[EFF_RST_BIT];
  wire rstLevel = cfg_q.rstSrcEn.faultLevel && atInter && wdogMax &&
                  cfg_q.faultCountEffectSel[FLT_EFF_RST_BIT];
  wire rstCfg = rstWdog || rstLevel ||
                (cfg_q.rstSrcEn.underVolt && uvRise) ||
                (cfg_q.rstSrcEn.overVolt && ovRise) ||
                (cfg_q.rstSrcEn.feedback && faultRise.feedbackFault);
  wire rstCause = rstFixed || rstCfg;
  wire rstNew = rstCause && (rstCnt_q == 16'h0000);

  // ****************************************
  // primary safe output causes
  // ****************************************
  // fixed primary causes
  wire safeFixed = faults_q.preregOv || initRefreshBad ||
                   faults_q.selftestFail || faults_q.resetShortHigh ||
                   faults_q.secondaryShortHigh || spiSafeReq ||
                   doubleErrorDetect;
  wire safeWdog = cfg_q.safeSrcEn.wdogMax && wdogMax &&
                  cfg_q.wdogEffectSel[EFF_SAFE_BIT];
  wire safeLevel = cfg_q.safeSrcEn.faultLevel && atInter &&
                   cfg_q.faultCountEffectSel[FLT_EFF_SAFE_BIT];
  wire safeCfg = safeWdog || safeLevel ||
                 (cfg_q.safeSrcEn.underVolt && uvLevel) ||
                 (cfg_q.safeSrcEn.overVolt && ovLevel) ||
                 (cfg_q.safeSrcEn.feedback && faults_q.feedbackFault) ||
                 (cfg_q.safeSrcEn.extIc && faults_q.extIcErr);
  wire safeCause = safeFixed || safeCfg;
  wire safeNew = safeCause && primarySafeOutN_q;

  // ****************************************
  // fault counter
  // ****************************************
  // one step per cycle with any assertion event or wdog maximum
  wire faultInc = wdogMax || rstNew || safeNew;

  always_comb begin
    faultCount_d = faultCount_q;
    // start level after low power exit
    if (lowPowerOffExit) begin
      faultCount_d = FLT_START;
    end else if (faultInc && !faultDec) begin
      if (faultCount_q != FLT_MAX) begin
        faultCount_d = faultCount_q + 3'h1;
      end
    // decrement after limit plus one goods
    end else if (faultDec && !faultInc && faultCount_q != 3'h0) begin
      faultCount_d = faultCount_q - 3'h1;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // release needs zero count, no fault, unlock
  wire primaryRelease = primaryUnlockOk && faultCount_q == 3'h0 &&
                        !anyFaultLevel && !safeCause;
  // primary low after low power exit
  assign primaryN_d = (lowPowerOffExit || safeCause) ? 1'b0 :
                      primaryRelease ? 1'b1 : primarySafeOutN_q;
  wire primaryFall = primarySafeOutN_q && !primaryN_d;

  // reset pulse length is fixed so a stuck cause cannot hold reset forever
  assign rstCnt_d = rstNew ? 16'(RST_HOLD_CYC) :
                    (rstCnt_q != 16'h0000) ? rstCnt_q - 16'h0001 : rstCnt_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      faultCount_q <= FLT_START;
      primarySafeOutN_q <= 1'b0;
      resetOutN_q <= 1'b1;
      rstCnt_q <= 16'h0000;
      wdogErrCount_q <= 4'h0;
      goodCount_q <= 3'h0;
      faultFinal_q <= 1'b0;
      pullupSwitchClosed_q <= 1'b0;
    end else begin
      faultCount_q <= faultCount_d;
      primarySafeOutN_q <= primaryN_d;
      resetOutN_q <= (rstCnt_d == 16'h0000);
      rstCnt_q <= rstCnt_d;
      wdogErrCount_q <= wdogErrCount_d;
      goodCount_q <= goodCount_d;
      faultFinal_q <= (faultCount_d >= finalLevel);
      // switch opens at reset, closed on request
      if (pullupSwitchCloseReq) begin
        pullupSwitchClosed_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // secondary output
  // ****************************************
  // tick restarted with each activation
  fsoc_ms_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clock(clock),
    .rst(rst),
    .clear(primaryFall),
    .tick(msTick)
  );

  // delay mode release gated by count and unlock
  fsoc_sec_timer u_sec (
    .clock(clock),
    .rst(rst),
    .msTick(msTick),
    .start(primaryFall),
    .secCfg(secCfg),
    .release_req(secondaryUnlockOk && faultCount_q == 3'h0),
    .switchClosed(pullupSwitchClosed_q),
    .secondaryN_q(secondarySafeOutN_q)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_limitGood;
    wdogGood && !wdogBad && goodAtLimit && faultCount_q != 3'h0 &&
    !lowPowerOffExit && !rstNew && !safeNew;
  endsequence

  AST_FAULT_WDOG_MAX: assert property (
    wdogMax && !lowPowerOffExit && faultCount_q != FLT_MAX
    |=> faultCount_q == $past(faultCount_q) + 3'h1)
    else $error("fault count missed watchdog maximum");
  AST_MODE01_PRIMARY: assert property (
    cfg_q.wdogEffectSel == 2'h1 && cfg_q.faultCountEffectSel == 2'h1 &&
    cfg_q.safeSrcEn.faultLevel && atInter |=> !primarySafeOutN_q)
    else $error("primary not low at intermediate level");
  AST_MODE10_RESET: assert property (
    cfg_q.wdogEffectSel == 2'h2 && cfg_q.faultCountEffectSel == 2'h2 &&
    cfg_q.rstSrcEn.faultLevel && atInter && wdogMax && rstCnt_q == 16'h0000
    |=> !resetOutN_q [*2])
    else $error("reset not pulsed at intermediate level");
  AST_LOW_POWER_OFF_START: assert property (
    lowPowerOffExit |=> faultCount_q == FLT_START && !primarySafeOutN_q)
    else $error("low power exit did not set start state");
  AST_RELEASE_ZERO: assert property (
    $rose(primarySafeOutN_q) |-> $past(faultCount_q) == 3'h0 &&
    $past(primaryUnlockOk))
    else $error("primary released with faults counted");
  AST_GOOD_DECREMENT: assert property (
    s_limitGood |=> faultCount_q == $past(faultCount_q) - 3'h1 &&
    goodCount_q == 3'h0)
    else $error("fault count not lowered after good refreshes");
  AST_SPI_RESET: assert property (
    spiResetReq && rstCnt_q == 16'h0000 |=> !resetOutN_q)
    else $error("spi reset request ignored");
  AST_SPI_SAFE: assert property (
    (spiSafeReq || doubleErrorDetect) |=> !primarySafeOutN_q)
    else $error("fixed primary cause ignored");
  AST_WDOG_ERR_STEP: assert property (
    wdogGood && !wdogBad && wdogErrCount_q != 4'h0
    |=> wdogErrCount_q == $past(wdogErrCount_q) - 4'h1)
    else $error("watchdog error count not lowered");
  AST_GOOD_CLEAR: assert property (
    wdogBad |=> goodCount_q == 3'h0)
    else $error("good counter not cleared by failure");
  AST_ASSERT_COUNT: assert property (
    safeNew && !wdogMax && !faultDec && !lowPowerOffExit &&
    faultCount_q != FLT_MAX |=> faultCount_q == $past(faultCount_q) + 3'h1)
    else $error("assertion not counted");
  // cfg_q only moves while the init phase is open, so a stable cfg means
  // the final flag was computed against the same level
  AST_FINAL_LEVEL: assert property (
    $stable(cfg_q) |-> faultFinal_q == (faultCount_q >= finalLevel))
    else $error("final level flag wrong");
  AST_CFG_FROZEN: assert property (
    !safetyInitPhase |=> $stable(cfg_q))
    else $error("configuration changed outside init phase");
  AST_PREREG_RESET: assert property (
    faultRise.preregOv && rstCnt_q == 16'h0000 |=> !resetOutN_q)
    else $error("overvoltage did not pulse reset");
  AST_PREREG_SAFE: assert property (
    faults_q.preregOv |=> !primarySafeOutN_q)
    else $error("overvoltage did not force primary low");
  AST_FAULT_HOLDS: assert property (
    !primarySafeOutN_q && anyFaultLevel |=> !primarySafeOutN_q)
    else $error("primary released while a fault stands");
  AST_GOOD_STEP: assert property (
    wdogGood && !wdogBad && !goodAtLimit |=> goodCount_q == $past(goodCount_q) + 3'h1)
    else $error("good counter not stepped");

endmodule

// ---- test/fsoc_mcu_model.sv ----
// microcontroller stand-in: refreshes the watchdog and sends spi requests
// assumes the core samples every request pulse on the rising clock edge
`timescale 1ns/10ps
module fsoc_mcu_model (
  // clock
  input wire logic clock,
  // state read back by software
  input wire logic [2:0] faultCount,
  // requests
  output logic wdogGood,
  output logic wdogBad,
  output logic spiSafeReq,
  output logic spiResetReq,
  output logic primaryUnlockOk,
  output logic secondaryUnlockOk,
  output logic pullupSwitchCloseReq
);
  // ****************************************
  // request pulses
  // ****************************************
  logic [6:0] req_q = 7'h00;

  assign {pullupSwitchCloseReq, secondaryUnlockOk, primaryUnlockOk,
    spiResetReq, spiSafeReq, wdogBad, wdogGood} = req_q;

  // one request, high for exactly one sampling edge
  task automatic pulse(input int idx);
    @(posedge clock);
    req_q[idx] <= 1'b1;
    @(posedge clock);
    req_q[idx] <= 1'b0;
  endtask

  // gap lets the bench act as a prompt or a slow refresher
  task automatic refresh(input logic good, input int n, input int gap);
    repeat (n) begin
      pulse(good ? 0 : 1);
      repeat (gap) @(posedge clock);
    end
  endtask

  // unlock after zero count
  // early skips the wait, only where a refusal is the point
  task automatic unlock(input int idx, input logic early);
    int w;
    w = 0;
    while (!early && faultCount !== 3'h0 && w < 100) begin
      @(posedge clock);
      w++;
    end
    pulse(idx);
  endtask
endmodule

// ---- test/fsoc_core_test.sv ----
// self-checking bench of the fail-safe output control core
// assumes fsoc_pkg and the microcontroller model are compiled first
`timescale 1ns/10ps
module fsoc_core_test
  import fsoc_pkg::*;
;
  // short tick keeps millisecond timing within a short run
  localparam int TICK = 10;
  localparam int SAFE = 2;
  localparam int RSTQ = 3;
  localparam int UNP = 4;
  localparam int UNS = 5;
  localparam int SWC = 6;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic lowPowerOffExit = 1'b0;
  logic safetyInitPhase = 1'b0;
  logic initRefreshBad = 1'b0;
  fsoc_cfg_t cfgIn = CFG_RESET;
  fsoc_sec_cfg_t secCfg = 6'h00;
  fsoc_faults_t faultsAsync = 13'h0000;
  wire logic wdogGood, wdogBad, spiSafeReq, spiResetReq;
  wire logic primaryUnlockOk, secondaryUnlockOk, pullupSwitchCloseReq;
  wire logic resetOutN_q, primarySafeOutN_q, secondarySafeOutN_q;
  wire logic pullupSwitchClosed_q, faultFinal_q;
  wire logic [2:0] faultCount_q;
  wire logic [3:0] wdogErrCount_q;
  int numErrors = 0;
  int testsRun = 0;
  logic [2:0] expQ[$];
  logic watchCnt = 1'b0;

  always #5 clock = ~clock;

  fsoc_core #(.TICK_CYC(TICK)) i_dut (.clock, .rst, .lowPowerOffExit,
    .safetyInitPhase, .wdogGood, .wdogBad, .initRefreshBad, .cfgIn,
    .secCfg, .spiResetReq, .spiSafeReq, .doubleErrorDetect(1'b0),
    .pullupSwitchCloseReq, .primaryUnlockOk, .secondaryUnlockOk,
    .faultsAsync, .resetOutN_q, .primarySafeOutN_q, .secondarySafeOutN_q,
    .pullupSwitchClosed_q, .faultCount_q, .faultFinal_q, .wdogErrCount_q);

  fsoc_mcu_model i_mcu (.clock, .faultCount(faultCount_q), .wdogGood,
    .wdogBad, .spiSafeReq, .spiResetReq, .primaryUnlockOk,
    .secondaryUnlockOk, .pullupSwitchCloseReq);

  // ****************************************
  // compares and verdict
  // ****************************************
  task automatic chkLvl(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkVal(input logic [3:0] got, input logic [3:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d of %0d checks", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // an unannounced count change compares against an impossible value
  always @(faultCount_q) begin
    if (watchCnt) begin
      if (expQ.size() == 0)
        chkVal({1'b0, faultCount_q}, 4'hF); // stray step
      else
        chkVal({1'b0, faultCount_q}, {1'b0, expQ.pop_front()}); // step
    end
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic waitRstHigh();
    int w;
    w = 0;
    while (resetOutN_q !== 1'b1 && w < 1100) begin
      w++;
      cyc(1);
    end
  endtask

  // six goods must not yet lower the count, the seventh must
  task automatic recover(input int gap);
    expQ.push_back(3'h0);
    i_mcu.refresh(1'b1, 6, gap);
    cyc(2);
    chkVal({1'b0, faultCount_q}, 4'h1); // not yet
    i_mcu.refresh(1'b1, 1, gap);
    i_mcu.unlock(UNP, 1'b0);
    cyc(2);
    chkLvl(primarySafeOutN_q, 1'b1); // released
  endtask

  task automatic fireSafe(input fsoc_sec_cfg_t sc);
    @(posedge clock);
    secCfg <= sc;
    expQ.push_back(3'h1);
    i_mcu.pulse(SAFE);
    cyc(1);
    chkLvl(primarySafeOutN_q, 1'b0); // spi request
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] seed;
    int code, n;
    seed = lfsrNext(32'h55d6_b373);
    code = 1 + int'(seed % 3);
    n = code * int'(STEP_SHORT_MS) * TICK;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    cyc(2);
    chkVal({1'b0, faultCount_q}, 4'h1); // start count
    chkLvl(primarySafeOutN_q, 1'b0); // start low
    chkLvl(secondarySafeOutN_q, 1'b1); // idle
    chkLvl(pullupSwitchClosed_q, 1'b0); // opens first
    chkLvl(faultFinal_q, 1'b0); // below final
    i_mcu.unlock(UNP, 1'b1);
    cyc(2);
    chkLvl(primarySafeOutN_q, 1'b0); // refused
    watchCnt = 1'b1;
    i_mcu.refresh(1'b1, 4, 0);
    i_mcu.refresh(1'b0, 1, 0);
    recover(0); // cleared by bad
    fireSafe({1'b0, code[3:0], 1'b0});
    chkLvl(secondarySafeOutN_q, 1'b1); // waits
    cyc(n * 9 / 10 - 1);
    chkLvl(secondarySafeOutN_q, 1'b1); // not early
    cyc(n / 5);
    chkLvl(secondarySafeOutN_q, 1'b0); // after delay
    recover(2);
    i_mcu.unlock(UNS, 1'b0);
    cyc(2);
    chkLvl(secondarySafeOutN_q, 1'b0); // switch open
    i_mcu.pulse(SWC);
    i_mcu.unlock(UNS, 1'b0);
    cyc(2);
    chkLvl(pullupSwitchClosed_q, 1'b1); // closed
    chkLvl(secondarySafeOutN_q, 1'b1); // spi release
    fireSafe(6'h00);
    chkLvl(secondarySafeOutN_q, 1'b0); // together
    recover(3);
    i_mcu.unlock(UNS, 1'b0);
    cyc(2);
    chkLvl(secondarySafeOutN_q, 1'b1); // spi release
    fireSafe({1'b1, code[3:0], 1'b0});
    chkLvl(secondarySafeOutN_q, 1'b0); // with primary
    cyc(n * 9 / 10 - 1);
    chkLvl(secondarySafeOutN_q, 1'b0); // not early
    cyc(n / 5);
    chkLvl(secondarySafeOutN_q, 1'b1); // self release
    recover(1);
    expQ.push_back(3'h1);
    i_mcu.pulse(RSTQ);
    cyc(1);
    n = 0;
    while (resetOutN_q === 1'b0 && n < 2000) begin
      n++;
      cyc(1);
    end
    chkLvl(n == RST_HOLD_CYC, 1'b1); // pulse length
    recover(0);
    // counts may step twice from here on, so stop watching them
    watchCnt = 1'b0;
    @(posedge clock);
    safetyInitPhase <= 1'b1;
    cfgIn <= '{2'h1, 2'h1, 1'b1, 3'h6, 3'h6, 6'h3F, 6'h3F};
    @(posedge clock);
    safetyInitPhase <= 1'b0;
    i_mcu.refresh(1'b0, 1, 0);
    cyc(1);
    chkVal(wdogErrCount_q, 4'h2); // adds two
    i_mcu.refresh(1'b0, 1, 0);
    i_mcu.refresh(1'b1, 1, 0);
    cyc(1);
    chkVal(wdogErrCount_q, 4'h3); // minus one
    i_mcu.refresh(1'b0, 1, 0);
    cyc(1);
    chkLvl(primarySafeOutN_q, 1'b1); // still high
    i_mcu.refresh(1'b0, 1, 0);
    cyc(3);
    chkVal(wdogErrCount_q, 4'h0); // max reached
    chkLvl(faultCount_q != 3'h0, 1'b1); // fault added
    chkLvl(resetOutN_q, 1'b0); // wdog on reset
    chkLvl(primarySafeOutN_q, 1'b0); // level one
    chkLvl(faultFinal_q, 1'b1); // final level
    waitRstHigh();
    @(posedge clock);
    faultsAsync.preregOv <= 1'b1;
    cyc(5);
    chkLvl(resetOutN_q, 1'b0); // fixed cause
    chkLvl(primarySafeOutN_q, 1'b0); // fixed cause
    @(posedge clock);
    faultsAsync <= 13'h0000;
    waitRstHigh();
    @(posedge clock);
    lowPowerOffExit <= 1'b1;
    @(posedge clock);
    lowPowerOffExit <= 1'b0;
    cyc(1);
    chkVal({1'b0, faultCount_q}, 4'h1); // reload
    chkLvl(primarySafeOutN_q, 1'b0); // low
    @(posedge clock);
    safetyInitPhase <= 1'b1;
    cfgIn <= '{2'h2, 2'h2, 1'b1, 3'h2, 3'h6, 6'h3F, 6'h3F};
    @(posedge clock);
    safetyInitPhase <= 1'b0;
    i_mcu.refresh(1'b0, 1, 0);
    cyc(1);
    chkLvl(resetOutN_q, 1'b0); // level and maximum
    chkVal({1'b0, faultCount_q}, 4'h2); // fault added
    waitRstHigh();
    @(posedge clock);
    initRefreshBad <= 1'b1;
    @(posedge clock);
    initRefreshBad <= 1'b0;
    cyc(1);
    chkLvl(resetOutN_q, 1'b0); // init refresh
    conclude();
  end

  initial begin
    repeat (30000) @(posedge clock);
    numErrors++;
    conclude();
  end
endmodule
